// *** src/asbp_pkg.sv ***
// Constants shared by the async byte-wide static memory host controller.
// Assumes a 100 MHz core clock; all memory timing is expressed in cycles of it.
package asbp_pkg;
   // ----------------------------------------
   // Clock and geometry
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDR_WIDTH = 17;
   localparam int DATA_WIDTH = 8;
   // ----------------------------------------
   // Pin timing, in the units printed
   // ----------------------------------------
   localparam int POWERUP_WAIT_US = 100;
   localparam int READ_CYCLE_NS = 10;
   localparam int ADDR_TO_DATA_NS = 10;
   localparam int WRITE_PULSE_NS = 8;
   localparam int STROBE_TO_FLOAT_DELAY_NS = 5;
   localparam int DATA_SETUP_TO_WRITE_END_NS = 5;
   // ----------------------------------------
   // Derived cycle counts (least times round up)
   // ----------------------------------------
   localparam int POWERUP_WAIT_CYC = (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_CYC = (ADDR_TO_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int WRITE_PULSE_CYC =
      ((STROBE_TO_FLOAT_DELAY_NS + DATA_SETUP_TO_WRITE_END_NS > WRITE_PULSE_NS ?
        STROBE_TO_FLOAT_DELAY_NS + DATA_SETUP_TO_WRITE_END_NS : WRITE_PULSE_NS)
       + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_WIDTH = 14;
   typedef enum logic [2:0] {
      ASBP_POWERUP,
      ASBP_IDLE,
      ASBP_RD,
      ASBP_WR_SETUP,
      ASBP_WR_PULSE,
      ASBP_WR_HOLD
   } asbp_state_e;
endpackage

// *** src/asbp_host.sv ***
// Host-side controller for a byte-wide asynchronous static memory.
// Assumes the memory pins are wired directly; the bench resolves the shared data wire.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Hold off all accesses until the supply has settled for the power-up wait.
// - Write starts with both select and strobe low; strobe rising ends it.
// - Write data stands stable before and after the strobe edge ending the write.
// - Strobe pulse covers output float delay plus data setup time.
// - Write strobe stays high throughout every read.
// - Address is valid no later than chip select falling for reads.
// - Host never drives the data lines while the memory may drive them.
// - Wait at least 100 microseconds after power before the first access.
module asbp_host
   import asbp_pkg::*;
#(
   parameter int POWERUP_CYCLES = POWERUP_WAIT_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Request side
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [ADDR_WIDTH-1:0] reqAddr,
   input wire logic [DATA_WIDTH-1:0] reqWdata,
   output logic reqReady,
   output logic rspValid,
   output logic [DATA_WIDTH-1:0] rspRdata,
   // Memory pins
   output logic [ADDR_WIDTH-1:0] memAddr,
   output logic memChipSelN,
   output logic memOutEnN,
   output logic memWrStrobeN,
   input wire logic [DATA_WIDTH-1:0] dataLinesIn,
   output logic [DATA_WIDTH-1:0] dataLinesOut,
   output logic dataLinesOe
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   asbp_state_e state_reg;
   logic [CNT_WIDTH-1:0] cnt_reg;
   logic [DATA_WIDTH-1:0] dataSync1_reg;
   logic [DATA_WIDTH-1:0] dataSync2_reg;
   logic cntDone;
   logic [CNT_WIDTH-1:0] strobeLowCnt_reg;

   assign cntDone = (cnt_reg == '0);

   // Data pins come from outside the clock domain; double register them
   // Bits may skew by a cycle; the read window waits for them to settle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         dataSync1_reg <= 8'h00;
         dataSync2_reg <= 8'h00;
      end else if (clkEn) begin
         dataSync1_reg <= dataLinesIn;
         dataSync2_reg <= dataSync1_reg;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ASBP_POWERUP;
         cnt_reg <= CNT_WIDTH'(POWERUP_CYCLES - 1);
      end else if (clkEn) begin
         unique case (state_reg)
            ASBP_POWERUP: begin
               if (cntDone) begin
                  state_reg <= ASBP_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ASBP_IDLE: begin
               if (reqValid) begin
                  // Extra sync delay lets read data pass the two flops
                  cnt_reg <= reqWrite ? CNT_WIDTH'(0) : CNT_WIDTH'(READ_CYC + 1);
                  state_reg <= reqWrite ? ASBP_WR_SETUP : ASBP_RD;
               end
            end
            ASBP_RD: begin
               if (cntDone) begin
                  state_reg <= ASBP_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ASBP_WR_SETUP: begin
               cnt_reg <= CNT_WIDTH'(WRITE_PULSE_CYC - 1);
               state_reg <= ASBP_WR_PULSE;
            end
            ASBP_WR_PULSE: begin
               if (cntDone) begin
                  state_reg <= ASBP_WR_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            ASBP_WR_HOLD: begin
               state_reg <= ASBP_IDLE;
            end
            // Unused codes fall back to idle rather than lock up
            default: begin
               state_reg <= ASBP_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   // Strobe rises a cycle before select so the write never ends on both edges at once
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         memAddr <= '0;
         memChipSelN <= 1'b1;
         memOutEnN <= 1'b1;
         memWrStrobeN <= 1'b1;
         dataLinesOut <= 8'h00;
         dataLinesOe <= 1'b0;
      end else if (clkEn) begin
         if (state_reg == ASBP_IDLE && reqValid) begin
            // Address set on the same edge that select falls
            memAddr <= reqAddr;
            dataLinesOut <= reqWdata;
            memChipSelN <= 1'b0;
            memOutEnN <= reqWrite;
            memWrStrobeN <= 1'b1;
            dataLinesOe <= 1'b0;
         end else if (state_reg == ASBP_WR_SETUP) begin
            // Output enable is high, so the memory is already floating
            memWrStrobeN <= 1'b0;
            dataLinesOe <= 1'b1;
         end else if (state_reg == ASBP_WR_PULSE && cntDone) begin
            // Strobe ends the write; select and data held one more cycle
            memWrStrobeN <= 1'b1;
         end else if (state_reg == ASBP_WR_HOLD || (state_reg == ASBP_RD && cntDone)) begin
            memChipSelN <= 1'b1;
            memOutEnN <= 1'b1;
            dataLinesOe <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Request handshake
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reqReady <= 1'b0;
         rspValid <= 1'b0;
         rspRdata <= 8'h00;
      end else if (clkEn) begin
         reqReady <= (state_reg == ASBP_IDLE && !reqValid) || state_reg == ASBP_WR_HOLD ||
                     (state_reg == ASBP_RD && cntDone) || (state_reg == ASBP_POWERUP && cntDone);
         rspValid <= (state_reg == ASBP_RD && cntDone) || state_reg == ASBP_WR_HOLD;
         // Read byte stands until the next read completes
         if (state_reg == ASBP_RD && cntDone) begin
            rspRdata <= dataSync2_reg;
         end
      end
   end

   // ----------------------------------------
   // Strobe width tracking
   // ----------------------------------------
   // Counts enabled cycles with the strobe low; a frozen clock only lengthens the real pulse
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         strobeLowCnt_reg <= '0;
      end else if (clkEn) begin
         strobeLowCnt_reg <= memWrStrobeN ? '0 : strobeLowCnt_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_READ_STROBE_HIGH: assert property (@(posedge core_clk) disable iff (!nrst)
      (!memOutEnN) |-> memWrStrobeN) else $error("Strobe low during read");
   AST_NO_DRIVE_WHILE_OE: assert property (@(posedge core_clk) disable iff (!nrst)
      dataLinesOe |-> memOutEnN) else $error("Host drives while memory may drive");
   AST_STROBE_NEEDS_SELECT: assert property (@(posedge core_clk) disable iff (!nrst)
      (!memWrStrobeN) |-> !memChipSelN) else $error("Strobe without select");
   AST_DATA_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
      ($rose(memWrStrobeN) && clkEn) |-> (dataLinesOe && !memChipSelN && $stable(dataLinesOut)))
      else $error("Data not held at write end");
   AST_ADDR_STABLE_WR: assert property (@(posedge core_clk) disable iff (!nrst)
      (!memChipSelN && !$fell(memChipSelN)) |-> $stable(memAddr)) else $error("Address moved while selected");
   AST_NO_EARLY_ACCESS: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ASBP_POWERUP) |-> memChipSelN) else $error("Access before power-up wait");
   AST_PULSE_WIDTH: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(memWrStrobeN) |-> (strobeLowCnt_reg >= CNT_WIDTH'(WRITE_PULSE_CYC))) else $error("Write strobe too short");
   AST_FLOAT_BEFORE_DRIVE: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(dataLinesOe) |-> $past(memOutEnN)) else $error("Host drives before memory output is off");
   AST_STROBE_ENDS_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(memChipSelN) |-> $past(memWrStrobeN)) else $error("Select rose with strobe still low");
   AST_WRITE_OUTPUTS_OFF: assert property (@(posedge core_clk) disable iff (!nrst)
      (!memWrStrobeN) |-> memOutEnN) else $error("Output enable low during write");
   AST_IDLE_DESELECTED: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ASBP_IDLE) |-> memChipSelN) else $error("Memory selected while idle");
   AST_READ_NEEDS_SELECT: assert property (@(posedge core_clk) disable iff (!nrst)
      (!memOutEnN) |-> !memChipSelN) else $error("Output enable low without select");
   AST_DRIVE_ONLY_IN_WRITE: assert property (@(posedge core_clk) disable iff (!nrst)
      dataLinesOe |-> !memChipSelN) else $error("Data driven while deselected");
endmodule
`default_nettype wire

// *** tb/asbp_sram_model.sv ***
// Behavioural byte-wide static memory on the far side of the host controller.
// Assumes the bench feeds it the host's data and enable; it returns the resolved wire.
`timescale 1ns/1ps
`default_nettype none
module asbp_sram_model
   import asbp_pkg::*;
(
   // Memory pins
   input wire logic [ADDR_WIDTH-1:0] memAddr,
   input wire logic memChipSelN,
   input wire logic memOutEnN,
   input wire logic memWrStrobeN,
   // Host side of the data wire
   input wire logic [DATA_WIDTH-1:0] hostData,
   input wire logic hostOe,
   output logic [DATA_WIDTH-1:0] dataLines
);
   logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];
   logic [DATA_WIDTH-1:0] lastVal = 8'h00;
   wire logic wrWin = !memChipSelN && !memWrStrobeN;
   wire logic rdOn = !memChipSelN && !memOutEnN && memWrStrobeN;
   always @(negedge wrWin) mem[memAddr] = hostData;
   // A floating wire shows the inverse of its last value, so a stale read cannot pass
   always @* begin
      if (rdOn && hostOe) dataLines = 8'hxx;
      else if (rdOn) dataLines = mem[memAddr];
      else if (hostOe) dataLines = hostData;
      else dataLines = ~lastVal;
   end
   always @(dataLines) if (rdOn || hostOe) lastVal = dataLines;
endmodule
`default_nettype wire

// *** tb/async_sram_byte_port_test.sv ***
// Self-checking bench: host controller against a behavioural byte memory.
// Assumes a shortened power-up count; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module async_sram_byte_port_test
   import asbp_pkg::*;
;
   localparam int PWR = 20;
   logic core_clk = 1'b0, nrst = 1'b0, clkEn = 1'b1, reqValid = 1'b0, reqWrite = 1'b0;
   logic reqReady, rspValid, memChipSelN, memOutEnN, memWrStrobeN, dataLinesOe;
   logic [ADDR_WIDTH-1:0] reqAddr = '0, memAddr;
   logic [DATA_WIDTH-1:0] reqWdata = '0, rspRdata, dataLinesIn, dataLinesOut;
   int errCount = 0, checked = 0, upCnt = 0;
   // Write flag, address, byte written or expected back
   logic [25:0] rows [8] = '{{1'b1, 17'h00000, 8'ha5}, {1'b1, 17'h1ffff, 8'h3c}, {1'b0, 17'h00000, 8'ha5},
      {1'b0, 17'h1ffff, 8'h3c}, {1'b1, 17'h0abcd, 8'h00}, {1'b1, 17'h0abcd, 8'hff}, {1'b0, 17'h0abcd, 8'hff},
      {1'b0, 17'h1ffff, 8'h3c}};
   asbp_host #(.POWERUP_CYCLES(PWR)) dut (.core_clk(core_clk), .nrst(nrst), .clkEn(clkEn), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqReady(reqReady), .rspValid(rspValid),
      .rspRdata(rspRdata), .memAddr(memAddr), .memChipSelN(memChipSelN), .memOutEnN(memOutEnN),
      .memWrStrobeN(memWrStrobeN), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
   asbp_sram_model mem (.memAddr(memAddr), .memChipSelN(memChipSelN), .memOutEnN(memOutEnN),
      .memWrStrobeN(memWrStrobeN), .hostData(dataLinesOut), .hostOe(dataLinesOe), .dataLines(dataLinesIn));
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Every wait is bounded; running out counts as a mismatch
   task automatic tick(inout int n);
      @(negedge core_clk);
      n++;
      if (n > 200) begin
         errCount++;
         test_done();
      end
   endtask
   // Hold the request until taken, optionally freeze the clock enable, then time the answer
   task automatic xfer(input logic [25:0] r, input int hold);
      int n;
      n = 0;
      {reqWrite, reqAddr, reqWdata} = r;
      reqValid = 1'b1;
      while (reqReady !== 1'b1) tick(n);
      tick(n);
      reqValid = 1'b0;
      clkEn = (hold == 0);
      n = 0;
      while (rspValid !== 1'b1) begin
         if (n == hold) clkEn = 1'b1;
         tick(n);
      end
      // Write: setup, pulse, hold; read: access plus two synchroniser cycles
      check(n, (r[25] ? WRITE_PULSE_CYC + 2 : READ_CYC + 2) + hold);
      if (!r[25]) check(rspRdata, r[7:0]);
   endtask
   // Pin watcher
   always @(negedge core_clk) begin
      upCnt = nrst ? upCnt + 1 : 0;
      if (nrst && !memChipSelN) check(upCnt >= PWR, 1'b1);
      if (nrst && upCnt < PWR) check(reqReady, 1'b0);
      if (nrst && !memChipSelN) check(memAddr, reqAddr);
      if (nrst && !memOutEnN) check(memWrStrobeN, 1'b1);
      if (nrst && !memWrStrobeN) check({memChipSelN, dataLinesOe, dataLinesOut}, {2'b01, reqWdata});
      if (nrst && dataLinesOe) check(memOutEnN, 1'b1);
   end
   initial begin
      repeat (2) @(negedge core_clk);
      nrst = 1'b1;
      for (int i = 0; i < 8; i++) begin
         xfer(rows[i], 0);
         $display("row %0d done", i);
      end
      // Reset in mid-read must idle every pin at once, then power-up is waited again
      {reqWrite, reqAddr} = {1'b0, 17'h1ffff};
      reqValid = 1'b1;
      repeat (4) @(negedge core_clk);
      nrst = 1'b0;
      reqValid = 1'b0;
      #1 check({memChipSelN, memOutEnN, memWrStrobeN, dataLinesOe, rspValid}, 5'h1c);
      @(negedge core_clk);
      nrst = 1'b1;
      xfer(rows[2], 3);
      $display("reset and freeze done");
      test_done();
   end
endmodule
`default_nettype wire
